/* File: logic/tsc_trig_status.v */
// Function
// - idle at reset, reset command, abort
// - leave idle only when initiated
// - reset command clears continuous flag
// - armed state samples selected trigger source
// - immediate true, bus on trigger, hold never
// - true trigger starts sweep, leaves armed
// - forced trigger once while armed
// - sweep end: idle or re-arm per flag
// - abort ends sweep, keeps other settings
// - clear-status clears status, queues, pending flag
// - event enable written 0-255, readable
// - event status query returns then clears
// - operation-complete sets bit when done
// - completion query queues ascii one, message-available
// - reset keeps queue, status, event register
// - service enable written 0-255, zero clears
// - service enable query bit 6 zero
// - status byte query, summary bit, no clear
// - self-test queues errors, returns count
// - wait stalls later commands until done
// - save and recall slots 0-9
// - trigger command acts as group trigger
// - bad initiate ignored, logs -213
// - completion flag in event bit 0
// - summary bit is or of enabled bits
`timescale 1ns/1ps
`include "tsc_consts.vh"

module tsc_trig_status #(
    parameter SWLEN_W  = 16,
    parameter EQ_DEPTH = 4,
    parameter EQ_AW    = 2
) (
    input  wire        clock,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        get_msg,
    input  wire        st_fault,
    input  wire        ques_evt,
    output reg         sweep_active,
    output reg         trig_armed,
    output reg         sweep_start,
    output reg         srq_mss
);

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg [1:0]         state_r;
reg [1:0]         state_nxt;
reg               cont_r;
reg [1:0]         src_r;
reg [SWLEN_W-1:0] swlen_r;
reg [SWLEN_W-1:0] swcnt_r;
reg               sw_done_r;
reg               cmd_pend_r;
reg [7:0]         cmd_op_r;
reg [7:0]         cmd_arg_r;
reg [7:0]         ese_r;
reg [7:0]         sre_r;
reg [7:0]         esr_r;
reg               opc_pend_r;
reg               oq_vld_r;
reg [7:0]         oq_data_r;
reg               ques_r;
reg               oper_r;
reg [15:0]        eq_mem [0:EQ_DEPTH-1];
reg [EQ_AW-1:0]   eq_wp_r;
reg [EQ_AW-1:0]   eq_rp_r;
reg [EQ_AW:0]     eq_cnt_r;
reg               sav_cont [0:9];
reg [1:0]         sav_src [0:9];
reg [SWLEN_W-1:0] sav_len [0:9];
reg [9:0]         sav_vld_r;
reg               get_s1, get_s2, get_s3;
reg               st_s1, st_s2;
reg               q_s1, q_s2;

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
// third get stage only feeds the edge detector, never the first
always @(posedge clock) begin
    if (rst) begin
        get_s1 <= 1'b0;
        get_s2 <= 1'b0;
        get_s3 <= 1'b0;
        st_s1  <= 1'b0;
        st_s2  <= 1'b0;
        q_s1   <= 1'b0;
        q_s2   <= 1'b0;
    end else begin
        get_s1 <= get_msg;
        get_s2 <= get_s1;
        get_s3 <= get_s2;
        st_s1  <= st_fault;
        st_s2  <= st_s1;
        q_s1   <= ques_evt;
        q_s2   <= q_s1;
    end
end

// ----------------------------------------------------------------
// command decode
// ----------------------------------------------------------------
wire sweeping = (state_r == `TSC_ST_SWEEP);
wire idle     = (state_r == `TSC_ST_IDLE);
wire armed    = (state_r == `TSC_ST_ARMED);
// wait and the completion query hold the command slot during a sweep
wire blocked  = sweeping & ((cmd_op_r == `TSC_OP_WAI) | (cmd_op_r == `TSC_OP_OPCQ));
wire exec     = cmd_pend_r & ~blocked;
wire is_op_rst = exec & (cmd_op_r == `TSC_OP_RST);
wire is_op_cls = exec & (cmd_op_r == `TSC_OP_CLS);
wire abort_now = exec & ((cmd_op_r == `TSC_OP_ABORT) | (cmd_op_r == `TSC_OP_RST));
wire init_bad  = idle == 1'b0 || cont_r;
wire slot_ok   = (cmd_arg_r <= `TSC_SLOT_MAX);
wire [3:0] slot = cmd_arg_r[3:0];
wire get_edge  = get_s2 & ~get_s3;
wire bus_trg   = get_edge | (exec & (cmd_op_r == `TSC_OP_TRG));
wire force_trg = exec & (cmd_op_r == `TSC_OP_TRIMM);
wire trig_true = (src_r == `TSC_SRC_IMM) | ((src_r == `TSC_SRC_BUS) & bus_trg) | force_trg;
wire arm_req   = exec & (((cmd_op_r == `TSC_OP_INIT) & ~init_bad)
                 | ((cmd_op_r == `TSC_OP_INITC) & cmd_arg_r[0] & idle));
wire [7:0] stb = {oper_r, 1'b0, |(esr_r & ese_r), oq_vld_r, ques_r, (eq_cnt_r != 0), 2'b00};
wire mss       = |(stb & sre_r);

// ----------------------------------------------------------------
// apb slave
// ----------------------------------------------------------------
// every access waits while a command is unfinished, keeping order
wire acc  = psel & penable & ~pready & ~cmd_pend_r;
wire done = psel & penable & pready;
reg [31:0] rd_nxt;
reg        err_nxt;

// read mux and unmapped decode
always @* begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    case (paddr)
        `TSC_A_CMD:   rd_nxt = {31'h0000_0000, cmd_pend_r};
        `TSC_A_OQ:    rd_nxt = {23'h00_0000, oq_vld_r, oq_data_r};
        `TSC_A_ERR:   rd_nxt = (eq_cnt_r != 0) ? {16'h0000, eq_mem[eq_rp_r]} : 32'h0000_0000;
        `TSC_A_STAT:  rd_nxt = {16'h0000, stb[7], mss, stb[5:0], 2'b00, cmd_pend_r, src_r, cont_r, state_r};
        `TSC_A_SWLEN: rd_nxt = {{(32-SWLEN_W){1'b0}}, swlen_r};
        default:      err_nxt = 1'b1;
    endcase
end

// one wait state, then ready with data
always @(posedge clock) begin
    if (rst) begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
    end else begin
        pready  <= acc;
        pslverr <= acc & err_nxt;
        if (acc) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
        end
    end
end

wire wr_done = done & pwrite;
wire rd_done = done & ~pwrite;
wire oq_pop  = rd_done & (paddr == `TSC_A_OQ);
wire eq_pop  = rd_done & (paddr == `TSC_A_ERR) & (eq_cnt_r != 0);

// ----------------------------------------------------------------
// command slot
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (rst) begin
        cmd_pend_r <= 1'b0;
        cmd_op_r   <= 8'h00;
        cmd_arg_r  <= 8'h00;
    end else if (wr_done && paddr == `TSC_A_CMD) begin
        cmd_pend_r <= 1'b1;
        cmd_op_r   <= pwdata[7:0];
        cmd_arg_r  <= pwdata[15:8];
    end else if (exec) begin
        cmd_pend_r <= 1'b0;
    end
end

// ----------------------------------------------------------------
// trigger state machine
// ----------------------------------------------------------------
always @* begin
    state_nxt = state_r;
    case (state_r)
        `TSC_ST_IDLE: begin
            if (arm_req) begin
                state_nxt = `TSC_ST_ARMED;
            end
        end
        `TSC_ST_ARMED: begin
            if (trig_true) begin
                state_nxt = `TSC_ST_SWEEP;
            end
        end
        `TSC_ST_SWEEP: begin
            if (sw_done_r) begin
                state_nxt = cont_r ? `TSC_ST_ARMED : `TSC_ST_IDLE;
            end
        end
        default: state_nxt = `TSC_ST_IDLE;
    endcase
    if (abort_now) begin
        state_nxt = `TSC_ST_IDLE;
    end
end

always @(posedge clock) begin
    if (rst) begin
        state_r      <= `TSC_ST_IDLE;
        sweep_start  <= 1'b0;
        sweep_active <= 1'b0;
        trig_armed   <= 1'b0;
        srq_mss      <= 1'b0;
    end else begin
        state_r      <= state_nxt;
        sweep_start  <= armed & (state_nxt == `TSC_ST_SWEEP);
        sweep_active <= (state_nxt == `TSC_ST_SWEEP);
        trig_armed   <= (state_nxt == `TSC_ST_ARMED);
        srq_mss      <= mss;
    end
end

// ----------------------------------------------------------------
// sweep engine
// ----------------------------------------------------------------
// length counted in clocks; abort kills the done pulse
always @(posedge clock) begin
    if (rst) begin
        swcnt_r   <= {SWLEN_W{1'b0}};
        sw_done_r <= 1'b0;
    end else begin
        if (!sweeping || sw_done_r) begin
            swcnt_r <= {SWLEN_W{1'b0}};
        end else begin
            swcnt_r <= swcnt_r + 1'b1;
        end
        sw_done_r <= sweeping & ~sw_done_r & ~abort_now & (swcnt_r == swlen_r - 1'b1);
    end
end

// ----------------------------------------------------------------
// user settings, save and recall
// ----------------------------------------------------------------
// recall of a never-saved slot gives the reset defaults
always @(posedge clock) begin
    if (rst) begin
        cont_r    <= 1'b0;
        src_r     <= `TSC_SRC_IMM;
        swlen_r   <= `TSC_SWLEN_RST;
        sav_vld_r <= 10'h000;
    end else if (is_op_rst) begin
        cont_r  <= 1'b0;
        src_r   <= `TSC_SRC_IMM;
        swlen_r <= `TSC_SWLEN_RST;
    end else if (exec) begin
        case (cmd_op_r)
            `TSC_OP_INITC: cont_r <= cmd_arg_r[0];
            `TSC_OP_TSRC: begin
                if (cmd_arg_r <= {6'h00, `TSC_SRC_HOLD}) begin
                    src_r <= cmd_arg_r[1:0];
                end
            end
            `TSC_OP_SAV: begin
                if (slot_ok) begin
                    sav_vld_r[slot] <= 1'b1;
                end
            end
            `TSC_OP_RCL: begin
                if (slot_ok) begin
                    cont_r  <= sav_vld_r[slot] ? sav_cont[slot] : 1'b0;
                    src_r   <= sav_vld_r[slot] ? sav_src[slot] : `TSC_SRC_IMM;
                    swlen_r <= sav_vld_r[slot] ? sav_len[slot] : `TSC_SWLEN_RST;
                end
            end
            default: cont_r <= cont_r;
        endcase
    end else if (wr_done && paddr == `TSC_A_SWLEN) begin
        // a zero length would wrap to the longest sweep, so it becomes one
        swlen_r <= (pwdata[SWLEN_W-1:0] == 0) ? {{(SWLEN_W-1){1'b0}}, 1'b1} : pwdata[SWLEN_W-1:0];
    end
end

// slot storage, no reset needed behind the valid bits
always @(posedge clock) begin
    if (exec && cmd_op_r == `TSC_OP_SAV && slot_ok) begin
        sav_cont[slot] <= cont_r;
        sav_src[slot]  <= src_r;
        sav_len[slot]  <= swlen_r;
    end
end

// ----------------------------------------------------------------
// status, enables, output queue
// ----------------------------------------------------------------
reg [7:0]  esr_set;
reg        eq_push;
reg [15:0] eq_code;

always @* begin
    esr_set = 8'h00;
    eq_push = 1'b0;
    eq_code = 16'h0000;
    if (opc_pend_r && !sweeping) begin
        esr_set[`TSC_ESR_OPC] = 1'b1;
    end
    if (exec) begin
        case (cmd_op_r)
            `TSC_OP_INIT, `TSC_OP_INITC: begin
                if (cmd_op_r == `TSC_OP_INIT && init_bad) begin
                    eq_push = 1'b1;
                    eq_code = `TSC_E_INIT;
                    esr_set[`TSC_ESR_EXE] = 1'b1;
                end
            end
            `TSC_OP_SAV, `TSC_OP_RCL: begin
                if (!slot_ok) begin
                    eq_push = 1'b1;
                    eq_code = `TSC_E_DATA;
                    esr_set[`TSC_ESR_EXE] = 1'b1;
                end
            end
            `TSC_OP_TSTQ: begin
                if (st_s2) begin
                    eq_push = 1'b1;
                    eq_code = `TSC_E_SELF;
                    esr_set[`TSC_ESR_DDE] = 1'b1;
                end
            end
            `TSC_OP_CLS, `TSC_OP_ESE, `TSC_OP_ESEQ, `TSC_OP_ESRQ, `TSC_OP_OPC, `TSC_OP_OPCQ,
            `TSC_OP_RST, `TSC_OP_SRE, `TSC_OP_SREQ, `TSC_OP_STBQ, `TSC_OP_WAI, `TSC_OP_TRG,
            `TSC_OP_ABORT, `TSC_OP_TRIMM, `TSC_OP_TSRC: esr_set = esr_set;
            default: begin
                eq_push = 1'b1;
                eq_code = `TSC_E_CMD;
                esr_set[`TSC_ESR_CME] = 1'b1;
            end
        endcase
    end
end

// set always wins over clear on the same edge
always @(posedge clock) begin
    if (rst) begin
        ese_r      <= 8'h00;
        sre_r      <= 8'h00;
        esr_r      <= 8'h00;
        opc_pend_r <= 1'b0;
        oq_vld_r   <= 1'b0;
        oq_data_r  <= 8'h00;
        ques_r     <= 1'b0;
        oper_r     <= 1'b0;
    end else begin
        // reset command leaves queue, status byte and event register alone
        if (is_op_cls || (exec && cmd_op_r == `TSC_OP_ESRQ)) begin
            esr_r <= esr_set;
        end else begin
            esr_r <= esr_r | esr_set;
        end
        ques_r <= (is_op_cls ? 1'b0 : ques_r) | q_s2 | (exec & (cmd_op_r == `TSC_OP_TSTQ) & st_s2);
        oper_r <= (is_op_cls ? 1'b0 : oper_r) | (state_nxt != state_r && state_nxt != `TSC_ST_IDLE);
        if (is_op_cls || (opc_pend_r && !sweeping)) begin
            opc_pend_r <= 1'b0;
        end else if (exec && cmd_op_r == `TSC_OP_OPC) begin
            opc_pend_r <= 1'b1;
        end
        if (exec && cmd_op_r == `TSC_OP_ESE) begin
            ese_r <= cmd_arg_r;
        end
        if (exec && cmd_op_r == `TSC_OP_SRE) begin
            sre_r <= cmd_arg_r & ~(8'h01 << `TSC_STB_MSS);
        end
        // one-deep output queue; a new answer overwrites an unread one
        if (exec) begin
            case (cmd_op_r)
                `TSC_OP_ESEQ: begin oq_vld_r <= 1'b1; oq_data_r <= ese_r; end
                `TSC_OP_ESRQ: begin oq_vld_r <= 1'b1; oq_data_r <= esr_r; end
                `TSC_OP_SREQ: begin oq_vld_r <= 1'b1; oq_data_r <= sre_r; end
                `TSC_OP_STBQ: begin oq_vld_r <= 1'b1; oq_data_r <= stb | {1'b0, mss, 6'h00}; end
                `TSC_OP_OPCQ: begin oq_vld_r <= 1'b1; oq_data_r <= `TSC_OPC_ONE; end
                `TSC_OP_TSTQ: begin oq_vld_r <= 1'b1; oq_data_r <= {7'h00, st_s2}; end
                `TSC_OP_CLS:  oq_vld_r <= 1'b0;
                default:      oq_vld_r <= oq_vld_r;
            endcase
        end else if (oq_pop) begin
            oq_vld_r <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// error queue
// ----------------------------------------------------------------
// a push into a full queue is dropped; the oldest entries survive
wire eq_wr = eq_push & (eq_cnt_r != EQ_DEPTH);
wire eq_rd = eq_pop & ~is_op_cls;

always @(posedge clock) begin
    if (eq_wr) begin
        eq_mem[eq_wp_r] <= eq_code;
    end
end

always @(posedge clock) begin
    if (rst || is_op_cls) begin
        eq_wp_r  <= {EQ_AW{1'b0}};
        eq_rp_r  <= {EQ_AW{1'b0}};
        eq_cnt_r <= {(EQ_AW+1){1'b0}};
    end else begin
        if (eq_wr) begin
            eq_wp_r <= eq_wp_r + 1'b1;
        end
        if (eq_rd) begin
            eq_rp_r <= eq_rp_r + 1'b1;
        end
        eq_cnt_r <= eq_cnt_r + {{EQ_AW{1'b0}}, eq_wr} - {{EQ_AW{1'b0}}, eq_rd};
    end
end

endmodule // tsc_trig_status

/* File: logic/tsc_consts.vh */
`ifndef TSC_CONSTS_VH
`define TSC_CONSTS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TSC_A_CMD    8'h00
`define TSC_A_OQ     8'h04
`define TSC_A_ERR    8'h08
`define TSC_A_STAT   8'h0c
`define TSC_A_SWLEN  8'h10
// ----------------------------------------------------------------
// command opcodes (cmd register bits 7:0, argument in 15:8)
// ----------------------------------------------------------------
`define TSC_OP_CLS   8'h01
`define TSC_OP_ESE   8'h02
`define TSC_OP_ESEQ  8'h03
`define TSC_OP_ESRQ  8'h04
`define TSC_OP_OPC   8'h05
`define TSC_OP_OPCQ  8'h06
`define TSC_OP_RST   8'h07
`define TSC_OP_SRE   8'h08
`define TSC_OP_SREQ  8'h09
`define TSC_OP_STBQ  8'h0a
`define TSC_OP_TSTQ  8'h0b
`define TSC_OP_WAI   8'h0c
`define TSC_OP_SAV   8'h0d
`define TSC_OP_RCL   8'h0e
`define TSC_OP_TRG   8'h0f
`define TSC_OP_INIT  8'h10
`define TSC_OP_INITC 8'h11
`define TSC_OP_ABORT 8'h12
`define TSC_OP_TRIMM 8'h13
`define TSC_OP_TSRC  8'h14
// ----------------------------------------------------------------
// trigger states and sources
// ----------------------------------------------------------------
`define TSC_ST_IDLE  2'h0
`define TSC_ST_ARMED 2'h1
`define TSC_ST_SWEEP 2'h2
`define TSC_SRC_IMM  2'h0
`define TSC_SRC_BUS  2'h1
`define TSC_SRC_HOLD 2'h2
// ----------------------------------------------------------------
// bit positions, codes, defaults
// ----------------------------------------------------------------
`define TSC_ESR_OPC  0
`define TSC_ESR_DDE  3
`define TSC_ESR_EXE  4
`define TSC_ESR_CME  5
`define TSC_STB_MSS  6
`define TSC_SLOT_MAX 8'h09
`define TSC_OPC_ONE  8'h31
`define TSC_E_INIT   16'hff2b
`define TSC_E_CMD    16'hff9c
`define TSC_E_DATA   16'hff22
`define TSC_E_SELF   16'h0001
`define TSC_SWLEN_RST 16'h0040
`endif

/* File: verification/tsc_trig_status_sva.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port-level checks on the trigger and status block
// ----------------------------------------------------------------
module tsc_trig_status_sva (
    input wire clock,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire sweep_active,
    input wire trig_armed,
    input wire sweep_start,
    input wire srq_mss
);
    // one domain, so clock and disable are declared once
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_rst_idle;
        $fell(rst) |-> !sweep_active && !trig_armed && !sweep_start && !srq_mss;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");

    property p_start_pulse;
        sweep_start |=> !sweep_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("sweep start longer than one cycle");

    property p_start_from_armed;
        sweep_start |-> $past(trig_armed) && sweep_active && !trig_armed;
    endproperty
    a_start_from_armed: assert property (p_start_from_armed) else $error("sweep not entered from armed");

    property p_rose_sweep;
        $rose(sweep_active) |-> sweep_start;
    endproperty
    a_rose_sweep: assert property (p_rose_sweep) else $error("sweep began without start pulse");

    property p_one_state;
        !(trig_armed && sweep_active);
    endproperty
    a_one_state: assert property (p_one_state) else $error("armed and sweeping together");

    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");

    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

    // one wait state at least: no answer in setup or first access cycle
    property p_wait_state;
        psel && !penable |-> !pready ##1 !pready;
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("answer came too early");

    property p_ready_needs_access;
        pready |-> $past(psel && penable);
    endproperty
    a_ready_needs_access: assert property (p_ready_needs_access) else $error("ready outside access");
endmodule // tsc_trig_status_sva

bind tsc_trig_status tsc_trig_status_sva chk_u (
    .clock        (clock),
    .rst          (rst),
    .psel         (psel),
    .penable      (penable),
    .pready       (pready),
    .pslverr      (pslverr),
    .sweep_active (sweep_active),
    .trig_armed   (trig_armed),
    .sweep_start  (sweep_start),
    .srq_mss      (srq_mss)
);

/* File: verification/tsc_host_bfm.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host controller: apb master issuing commands
// ----------------------------------------------------------------
module tsc_host_bfm (
    input  wire        clock,
    output reg         psel,
    output reg         penable,
    output reg         pwrite,
    output reg  [7:0]  paddr,
    output reg  [31:0] pwdata,
    input  wire [31:0] prdata,
    input  wire        pready,
    input  wire        pslverr
);
    initial {psel, penable, pwrite, paddr, pwdata} = 43'h0;

    // one transfer; waits for as long as the slave stalls
    task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q, output e);
        begin
            @(posedge clock);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clock);
            penable <= 1'b1;
            @(posedge clock);
            while (pready !== 1'b1) begin
                @(posedge clock);
            end
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // released lines show a changed pattern, not the old value
            paddr <= ~a;
            pwdata <= ~d;
        end
    endtask

    // one-byte argument keeps enables in 0-255
    task cmd(input [7:0] op, input [7:0] arg);
        reg [31:0] q;
        reg        e;
        begin
            xfer(1'b1, 8'h00, {16'h0, arg, op}, q, e);
        end
    endtask
endmodule // tsc_host_bfm

/* File: verification/trigger_and_status_commands_tb.sv */
`timescale 1ns/1ps
`include "tsc_consts.vh"
module trigger_and_status_commands_tb;
    reg         clock;
    reg         rst;
    reg         get_msg;
    reg         st_fault;
    reg         ques_evt;
    wire        psel, penable, pwrite, pready, pslverr;
    wire [7:0]  paddr;
    wire [31:0] pwdata, prdata;
    wire        sweep_active, trig_armed, sweep_start, srq_mss;
    integer     err_count, n_compared, i, v, m_state, m_src, m_cont;
    reg  [31:0] q;
    reg         e;

    always #2.5 clock = ~clock;

    tsc_host_bfm host_u (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    tsc_trig_status dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .get_msg(get_msg), .st_fault(st_fault), .ques_evt(ques_evt), .sweep_active(sweep_active),
        .trig_armed(trig_armed), .sweep_start(sweep_start), .srq_mss(srq_mss));

    // ----------------------------------------------------------------
    // compare, access and wait helpers
    // ----------------------------------------------------------------
    task chk(input [31:0] seen, input [31:0] exp, input string what);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("mismatch %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task rd(input [7:0] a);
        host_u.xfer(1'b0, a, 32'h0, q, e);
    endtask

    task wr(input [7:0] a, input [31:0] d);
        host_u.xfer(1'b1, a, d, q, e);
    endtask

    task cmd(input [7:0] op, input [7:0] arg);
        host_u.cmd(op, arg);
    endtask

    // state, cont flag and source against the model
    task chk_stat;
        begin
            rd(`TSC_A_STAT);
            chk(q[4:0], {m_src[1:0], m_cont[0], m_state[1:0]}, "stat");
        end
    endtask

    task chk_oq(input [8:0] exp);
        begin
            rd(`TSC_A_OQ);
            chk(q[8:0], exp, "oq");
        end
    endtask

    task wait_start;
        begin
            repeat (3000) if (sweep_start !== 1'b1) @(posedge clock);
            chk(sweep_start, 1'b1, "sweep_start");
        end
    endtask

    task wait_end;
        begin
            repeat (3000) if (sweep_active !== 1'b0) @(posedge clock);
            chk(sweep_active, 1'b0, "sweep_end");
        end
    endtask

    task complete_run;
        begin
            if (err_count == 0 && n_compared > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask

    // watchdog, far past the expected run
    initial begin
        #400000;
        err_count = err_count + 1;
        complete_run;
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        get_msg = 1'b0;
        st_fault = 1'b0;
        ques_evt = 1'b0;
        err_count = 0;
        n_compared = 0;
        m_state = 0;
        m_src = 0;
        m_cont = 0;
        v = $urandom(41);
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        chk_stat;
        rd(`TSC_A_SWLEN);
        chk(q, 32'h40, "swlen");
        rd(8'h20);
        chk(e, 1'b1, "pslverr");
        // hold source: armed forever, bus trigger ignored, forced trigger works
        wr(`TSC_A_SWLEN, 32'h4);
        cmd(`TSC_OP_TSRC, 8'h02);
        m_src = 2;
        cmd(`TSC_OP_INIT, 8'h00);
        m_state = 1;
        repeat (20) @(posedge clock);
        chk_stat;
        chk(trig_armed, 1'b1, "armed");
        cmd(`TSC_OP_TRG, 8'h00);
        chk_stat;
        cmd(`TSC_OP_INIT, 8'h00);
        rd(`TSC_A_ERR);
        chk(q[15:0], `TSC_E_INIT, "err");
        cmd(`TSC_OP_TRIMM, 8'h00);
        wait_start;
        wait_end;
        m_state = 0;
        chk_stat;
        // bus source with continuous re-arm
        cmd(`TSC_OP_TSRC, 8'h01);
        m_src = 1;
        cmd(`TSC_OP_INITC, 8'h01);
        m_cont = 1;
        m_state = 1;
        chk_stat;
        cmd(`TSC_OP_INIT, 8'h00);
        rd(`TSC_A_ERR);
        chk(q[15:0], `TSC_E_INIT, "err");
        cmd(`TSC_OP_TRG, 8'h00);
        wait_start;
        wait_end;
        chk_stat;
        get_msg <= 1'b1;
        wait_start;
        get_msg <= 1'b0;
        wait_end;
        chk_stat;
        // abort a long sweep, settings survive
        wr(`TSC_A_SWLEN, 32'd1000);
        cmd(`TSC_OP_TRG, 8'h00);
        wait_start;
        cmd(`TSC_OP_ABORT, 8'h00);
        m_state = 0;
        chk_stat;
        chk(sweep_active, 1'b0, "abort_active");
        rd(`TSC_A_SWLEN);
        chk(q, 32'd1000, "swlen");
        // save, reset, recall
        cmd(`TSC_OP_SAV, 8'h03);
        cmd(`TSC_OP_RST, 8'h00);
        m_cont = 0;
        m_src = 0;
        chk_stat;
        rd(`TSC_A_SWLEN);
        chk(q, 32'h40, "swlen");
        cmd(`TSC_OP_RCL, 8'h03);
        rd(`TSC_A_SWLEN);
        chk(q, 32'd1000, "recall");
        cmd(`TSC_OP_RST, 8'h00);
        // enable registers with random values
        for (i = 0; i < 3; i = i + 1) begin
            v = $urandom & 255;
            cmd(`TSC_OP_ESE, v[7:0]);
            cmd(`TSC_OP_ESEQ, 8'h00);
            chk_oq({1'b1, v[7:0]});
            cmd(`TSC_OP_SRE, v[7:0]);
            cmd(`TSC_OP_SREQ, 8'h00);
            chk_oq({1'b1, v[7:0] & 8'hbf});
        end
        cmd(`TSC_OP_RST, 8'h00);
        cmd(`TSC_OP_ESEQ, 8'h00);
        chk_oq({1'b1, v[7:0]});
        // summary bit follows error queue and its enable
        cmd(`TSC_OP_CLS, 8'h00);
        cmd(`TSC_OP_SRE, 8'h04);
        repeat (3) @(posedge clock);
        chk(srq_mss, 1'b0, "mss");
        cmd(8'h7f, 8'h00);
        repeat (3) @(posedge clock);
        chk(srq_mss, 1'b1, "mss");
        for (i = 0; i < 2; i = i + 1) begin
            cmd(`TSC_OP_STBQ, 8'h00);
            rd(`TSC_A_OQ);
            chk({q[8], q[6], q[2]}, 3'b111, "stb");
        end
        cmd(`TSC_OP_CLS, 8'h00);
        repeat (3) @(posedge clock);
        chk(srq_mss, 1'b0, "mss");
        rd(`TSC_A_ERR);
        chk(q[15:0], 16'h0, "err");
        cmd(`TSC_OP_SRE, 8'h00);
        cmd(`TSC_OP_SREQ, 8'h00);
        chk_oq(9'h100);
        // completion flag, its query, event register clear on read
        cmd(`TSC_OP_OPC, 8'h00);
        cmd(`TSC_OP_ESRQ, 8'h00);
        chk_oq(9'h101);
        cmd(`TSC_OP_ESRQ, 8'h00);
        chk_oq(9'h100);
        cmd(`TSC_OP_OPCQ, 8'h00);
        chk_oq({1'b1, `TSC_OPC_ONE});
        // wait holds the next access until the sweep ends
        cmd(`TSC_OP_INIT, 8'h00);
        cmd(`TSC_OP_WAI, 8'h00);
        chk_stat;
        // self-test pass then fail
        cmd(`TSC_OP_TSTQ, 8'h00);
        chk_oq(9'h100);
        st_fault <= 1'b1;
        repeat (4) @(posedge clock);
        cmd(`TSC_OP_TSTQ, 8'h00);
        chk_oq(9'h101);
        rd(`TSC_A_ERR);
        chk(q[15:0], `TSC_E_SELF, "err");
        st_fault <= 1'b0;
        complete_run;
    end
endmodule // trigger_and_status_commands_tb
